// >>> tb_top.sv
// self-checking bench of the serial channel core: apb master and remote model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0;
	logic        cts_n   = 1'b0;
	logic        tpin    = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx;
	logic        rx;
	logic        rts_n;
	logic        blocked;
	logic [31:0] rd;
	logic        err;
	int          fail_count = 0;
	int          checks     = 0;

	always #5 pclk = ~pclk;
	always #40 tpin = ~tpin;

	uccore_top uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_tx_out(tx), .serial_rx_in(rx),
		.clear_to_send_in_n(cts_n), .request_to_send_out_n(rts_n),
		.timer_clock_pin(tpin), .timer_capture_blocked_out(blocked));
	uccore_remote remote (.line_in(tx), .line_out(rx));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask : wr

	task automatic cmd(input int b);
		wr(uccore_pkg::OFS_CMD, 32'h1 << b);
	endtask : cmd

	// bounded wait on the transmit line; returns cycles spent
	task automatic wait_line(input logic v, input int lim, output int n);
		n = 0;
		while (tx !== v) begin
			@(posedge pclk);
			n++;
			if (n > lim) begin
				fail_count++;
				print_verdict();
			end
		end
	endtask : wait_line

	task automatic wait_rx(input int base);
		int n;
		n = 0;
		while (remote.got_cnt <= base) begin
			@(posedge pclk);
			n++;
			if (n > 14000) begin
				fail_count++;
				print_verdict();
			end
		end
	endtask : wait_rx

	task automatic status(input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, uccore_pkg::OFS_STATUS, 32'h0);
		check("status", rd & mask, exp);
	endtask : status

	task automatic rx_get(input logic [31:0] sts, input logic [31:0] dat);
		int n;
		n = 0;
		do begin
			apb(1'b0, uccore_pkg::OFS_STATUS, 32'h0);
			n++;
		end while (rd[2] !== 1'b1 && n < 100);
		check("rx status", rd & 32'h7c, sts);
		apb(1'b0, uccore_pkg::OFS_DATA, 32'h0);
		check("rx data", rd, dat);
		status(32'h04, 32'h0);
		cmd(uccore_pkg::CMD_ERR_RST);
	endtask : rx_get

	task automatic t_regs();
		check("tx idle", 32'(tx), 32'h1);
		check("rts reset", 32'(rts_n), 32'h1);
		check("capture free", 32'(blocked), 32'h0);
		apb(1'b0, uccore_pkg::OFS_CLKSEL, 32'h0);
		check("clksel reset", rd, 32'h0);
		apb(1'b0, uccore_pkg::OFS_MODE, 32'h0);
		check("mode reset", rd, 32'h3);
		wr(uccore_pkg::OFS_DIVLO, 32'h5);
		apb(1'b0, uccore_pkg::OFS_DIVLO, 32'h0);
		check("divider write only", rd, 32'h0);
		apb(1'b1, 8'h24, 32'hff);
		check("unmapped", 32'(err), 32'h1);
	endtask : t_regs

	task automatic t_rts();
		logic [7:0] a[4] = '{uccore_pkg::OFS_RTS_SET, uccore_pkg::OFS_RTS_SET,
			uccore_pkg::OFS_RTS_CLR, uccore_pkg::OFS_RTS_CLR};
		logic [31:0] d[4] = '{32'hfe, 32'h1, 32'hfe, 32'hff};
		logic e[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		for (int k = 0; k < 4; k++) begin
			wr(a[k], d[k]);
			check("rts", 32'(rts_n), 32'(e[k]));
		end
	endtask : t_rts

	task automatic t_clk();
		logic [1:0] s[3] = '{2'h2, 2'h1, 2'h0};
		for (int k = 0; k < 3; k++) begin
			wr(uccore_pkg::OFS_CLKSEL, 32'(s[k]));
			check("capture blocked", 32'(blocked), 32'(s[k] != 2'h0));
			apb(1'b0, uccore_pkg::OFS_CLKSEL, 32'h0);
			check("clksel", rd, 32'(s[k]));
		end
	endtask : t_clk

	// divider 2: sixteen ticks of 32*2 clocks make one bit
	task automatic t_baud();
		int n;
		int base;
		wr(uccore_pkg::OFS_DIVHI, 32'h0);
		wr(uccore_pkg::OFS_DIVLO, 32'h2);
		remote.bit_ns = 10240.0;
		base = remote.got_cnt;
		cmd(uccore_pkg::CMD_TX_EN);
		wr(uccore_pkg::OFS_DATA, 32'hc5);
		wait_line(1'b0, 3000, n);
		wait_line(1'b1, 2000, n);
		check("bit time", 32'(n), 32'd1024);
		wait_rx(base);
		check("char internal", 32'(remote.got), 32'hfc5);
	endtask : t_baud

	task automatic t_frames();
		logic [7:0] m[4] = '{8'h00, 8'h07, 8'h0e, 8'h13};
		logic [7:0] d[4] = '{8'h15, 8'h0b, 8'h41, 8'ha5};
		logic [11:0] e;
		int nb;
		int base;
		for (int k = 0; k < 4; k++) begin
			nb = 5 + int'(m[k][1:0]);
			e = 12'hfff;
			for (int i = 0; i < nb; i++)
				e[i] = d[k][i];
			if (m[k][2])
				e[nb] = (^d[k]) ^ m[k][3];
			remote.nbits = nb + int'(m[k][2]) + 1 + int'(m[k][4]);
			wr(uccore_pkg::OFS_MODE, 32'(m[k]));
			base = remote.got_cnt;
			wr(uccore_pkg::OFS_DATA, 32'(d[k]));
			wait_rx(base);
			check("tx frame", 32'(remote.got), 32'(e));
		end
		remote.nbits = 9;
		wr(uccore_pkg::OFS_MODE, 32'h3);
	endtask : t_frames

	// undivided timer pin: one pin period per bit
	task automatic t_sync();
		int base;
		wr(uccore_pkg::OFS_CLKSEL, 32'h2);
		remote.bit_ns = 80.0;
		base = remote.got_cnt;
		wr(uccore_pkg::OFS_DATA, 32'h3c);
		wait_rx(base);
		check("sync char", 32'(remote.got), 32'hf3c);
		wr(uccore_pkg::OFS_CLKSEL, 32'(uccore_pkg::CSEL_EXT16));
		remote.bit_ns = 1280.0;
	endtask : t_sync

	task automatic t_b2b();
		int n;
		int base;
		base = remote.got_cnt;
		wr(uccore_pkg::OFS_DATA, 32'h81);
		// second load only once the first has left the holding register
		wait_line(1'b0, 400, n);
		wr(uccore_pkg::OFS_DATA, 32'h18);
		status(32'h3, 32'h0);
		wait_rx(base + 1);
		check("second char", 32'(remote.got), 32'hf18);
		repeat (200) @(posedge pclk);
		status(32'h3, 32'h3);
	endtask : t_b2b

	task automatic t_cts();
		int n;
		int base;
		wr(uccore_pkg::OFS_MODE, 32'h23);
		base = remote.got_cnt;
		wr(uccore_pkg::OFS_DATA, 32'h11);
		wait_line(1'b0, 400, n);
		@(posedge pclk);
		cts_n <= 1'b1;
		wait_rx(base);
		check("char kept", 32'(remote.got), 32'hf11);
		wr(uccore_pkg::OFS_DATA, 32'h22);
		n = 0;
		repeat (400) begin
			@(posedge pclk);
			n += (tx !== 1'b1);
		end
		check("held mark", 32'(n), 32'h0);
		cmd(uccore_pkg::CMD_BRK_ON);
		wait_line(1'b0, 300, n);
		repeat (300) @(posedge pclk);
		check("break low", 32'(tx), 32'h0);
		cmd(uccore_pkg::CMD_BRK_OFF);
		wait_rx(base + 1);
		base = remote.got_cnt;
		@(posedge pclk);
		cts_n <= 1'b0;
		wait_rx(base);
		check("char after cts", 32'(remote.got), 32'hf22);
		wr(uccore_pkg::OFS_MODE, 32'h3);
	endtask : t_cts

	task automatic t_stop();
		int n;
		int base;
		base = remote.got_cnt;
		wr(uccore_pkg::OFS_DATA, 32'h69);
		wait_line(1'b0, 400, n);
		cmd(uccore_pkg::CMD_TX_DIS);
		wait_rx(base);
		check("finished on disable", 32'(remote.got), 32'hf69);
		status(32'h1, 32'h0);
		cmd(uccore_pkg::CMD_TX_EN);
		wr(uccore_pkg::OFS_DATA, 32'h0f);
		wait_line(1'b0, 400, n);
		wait_line(1'b1, 400, n);
		cmd(uccore_pkg::CMD_TX_RST);
		n = 0;
		repeat (1400) begin
			@(posedge pclk);
			n += (tx !== 1'b1);
		end
		check("reset abandons char", 32'(n), 32'h0);
		status(32'h1, 32'h0);
	endtask : t_stop

	task automatic t_autorts();
		int n;
		int base;
		cmd(uccore_pkg::CMD_TX_EN);
		wr(uccore_pkg::OFS_MODE, 32'h43);
		wr(uccore_pkg::OFS_RTS_SET, 32'h1);
		base = remote.got_cnt;
		wr(uccore_pkg::OFS_DATA, 32'h55);
		wait_line(1'b0, 400, n);
		cmd(uccore_pkg::CMD_TX_DIS);
		wait_rx(base);
		check("rts during stop", 32'(rts_n), 32'h0);
		n = 0;
		while (rts_n !== 1'b1 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		check("auto negate delay", 32'(n > 150 && n < 260), 32'h1);
	endtask : t_autorts

	task automatic t_rx();
		real b;
		b = remote.bit_ns;
		cmd(uccore_pkg::CMD_RX_EN);
		remote.pulse(b / 4.0);
		repeat (400) @(posedge pclk);
		status(32'h4, 32'h0);
		remote.send(12'h196, 9, b);
		rx_get(32'h04, 32'h96);
		wr(uccore_pkg::OFS_MODE, 32'h0);
		remote.send(12'hfff, 9, b);
		rx_get(32'h04, 32'h1f);
		wr(uccore_pkg::OFS_MODE, 32'h7);
		remote.send(12'h20b, 10, b);
		rx_get(32'h0c, 32'h0b);
		wr(uccore_pkg::OFS_MODE, 32'h3);
		remote.send(12'h05a, 9, b * 0.75);
		rx_get(32'h14, 32'h5a);
		remote.send(12'h000, 11, b);
		rx_get(32'h54, 32'h00);
		remote.send(12'h133, 9, b);
		rx_get(32'h04, 32'h33);
	endtask : t_rx

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_rts();
		t_clk();
		t_baud();
		wr(uccore_pkg::OFS_CLKSEL, 32'(uccore_pkg::CSEL_EXT16));
		remote.bit_ns = 1280.0;
		t_frames();
		t_sync();
		t_b2b();
		t_cts();
		t_stop();
		t_autorts();
		t_rx();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

// >>> uccore_pkg.sv
// shared constants, encodings and state types of the serial channel core
// How it works
// [RULE_01] bit0 writes assert or negate request-to-send
// [RULE_02] bus clock divided by 32 then divider
// [RULE_03] timer pin used raw or divided by 16
// [RULE_04] clock select field picks the source
// [RULE_05] timer capture blocked while pin clocks
// [RULE_06] tx ready flag shows holding register free
// [RULE_07] start, data lsb first, parity, stop bits
// [RULE_08] transmit on falling, receive on rising
// [RULE_09] idle mark and empty flag; load resumes
// [RULE_10] disable finishes the shifting character
// [RULE_11] software reset stops transmitter at once
// [RULE_12] clear-to-send gates character start only
// [RULE_13] break ignores clear-to-send
// [RULE_14] auto negate one bit after last character
// [RULE_15] start bit checked by eight samples
// [RULE_16] receive samples at bit centre
// [RULE_17] char to holding register, upper bits zero
// [RULE_18] restart search; low half bit is start
// [RULE_19] error flags updated at character boundary
// [RULE_20] full-character low stores zero with break
// [RULE_21] mid-character break stores both characters
// [RULE_22] software programs divider at least two
// [RULE_23] divider is high byte then low byte
// [RULE_24] divided clock is sixteen-times bit clock
package uccore_pkg;
	localparam logic [7:0] OFS_CMD     = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_DATA    = 8'h08;
	localparam logic [7:0] OFS_CLKSEL  = 8'h0c;
	localparam logic [7:0] OFS_DIVHI   = 8'h10;
	localparam logic [7:0] OFS_DIVLO   = 8'h14;
	localparam logic [7:0] OFS_RTS_SET = 8'h18;
	localparam logic [7:0] OFS_RTS_CLR = 8'h1c;
	localparam logic [7:0] OFS_MODE    = 8'h20;
	// command bits
	localparam int CMD_TX_EN  = 0;
	localparam int CMD_TX_DIS = 1;
	localparam int CMD_TX_RST = 2;
	localparam int CMD_RX_EN  = 3;
	localparam int CMD_RX_DIS = 4;
	localparam int CMD_RX_RST = 5;
	localparam int CMD_BRK_ON = 6;
	localparam int CMD_BRK_OFF = 7;
	localparam int CMD_ERR_RST = 8;
	// mode bits: [1:0] data bits minus five
	localparam int MODE_PAR_EN = 2;
	localparam int MODE_PAR_ODD = 3;
	localparam int MODE_STOP2  = 4;
	localparam int MODE_CTS_CHK = 5;
	localparam int MODE_AUTO_RTS = 6;
	localparam logic [6:0] MODE_RST = 7'h03;
	localparam logic [7:0] DIV_RST  = 8'h00;
	localparam logic [1:0] CSEL_INT   = 2'h0;
	localparam logic [1:0] CSEL_EXT16 = 2'h1;
	localparam logic [1:0] CSEL_RST   = 2'h0;
	localparam logic [4:0] PRE_LAST  = 5'h1f;
	localparam logic [3:0] OS_LAST   = 4'hf;
	localparam logic [3:0] HALF_LAST = 4'h7;
	localparam logic [3:0] BITS_MIN  = 4'h5;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
		TX_PAR = 3'h2, TX_STOP = 3'h6, TX_RTSW = 3'h7
	} uccore_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
		RX_PAR = 3'h2, RX_STOP = 3'h6, RX_BRKW = 3'h7
	} uccore_rx_t;
endpackage : uccore_pkg

// >>> uccore_remote.sv
// remote serial device model: sends characters to the core and captures its output
`timescale 1ns/100ps
`default_nettype none
module uccore_remote (
	// serial lines seen from the far side
	input  wire logic line_in,
	output var  logic line_out
);
	real         bit_ns  = 1280.0;
	int          nbits   = 9;
	int          got_cnt = 0;
	logic [11:0] got     = 12'hfff;

	initial line_out = 1'b1;

	// start, then n bits lsb first; last bit may be cut short to fake a bad stop
	task automatic send(input logic [11:0] w, input int n, input real last_ns);
		line_out <= 1'b0;
		#(bit_ns);
		for (int i = 0; i < n; i++) begin
			line_out <= w[i];
			#((i == n - 1) ? last_ns : bit_ns);
		end
		line_out <= 1'b1;
		#(bit_ns);
	endtask : send

	// non-blocking: calls start on a clock edge, so avoid racing the synchroniser
	task automatic pulse(input real ns);
		line_out <= 1'b0;
		#(ns);
		line_out <= 1'b1;
	endtask : pulse

	// capture data, parity and stops at bit centres; upper bits stay one
	always begin
		@(negedge line_in);
		#(bit_ns / 2.0);
		if (line_in === 1'b0) begin
			got = 12'hfff;
			for (int i = 0; i < nbits; i++) begin
				#(bit_ns);
				got[i] = line_in;
			end
			got_cnt++;
		end
	end
endmodule : uccore_remote
`default_nettype wire

// >>> uccore_top.sv
// serial channel core: clocking, transmitter, receiver, apb registers
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module uccore_top (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// serial pins
	output var  logic        serial_tx_out,
	input  wire logic        serial_rx_in,
	input  wire logic        clear_to_send_in_n,
	output var  logic        request_to_send_out_n,
	input  wire logic        timer_clock_pin,
	output var  logic        timer_capture_blocked_out
);
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [1:0]  csel;
		logic [7:0]  div_hi;
		logic [7:0]  div_lo;
		logic [6:0]  mode;
		logic [4:0]  pre;
		logic [15:0] divc;
		logic [1:0]  rx_s;
		logic        rx_d;
		logic [1:0]  cts_s;
		logic [1:0]  ext_s;
		logic        ext_d;
		logic        cap_blk;
		logic        rts_n;
		logic        txo;
		logic        brk;
		logic        tx_en;
		logic [7:0]  thr;
		logic        thr_full;
		logic        tx_empty;
		uccore_pkg::uccore_tx_t tx_st;
		logic [7:0]  tx_sh;
		logic        tx_par;
		logic [3:0]  tx_bit;
		logic [3:0]  tx_osc;
		logic        tx_line;
		logic        rx_en;
		uccore_pkg::uccore_rx_t rx_st;
		logic [3:0]  rx_osc;
		logic [3:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic        rx_pbit;
		logic [7:0]  rhr;
		logic        rx_ready;
		logic        pe;
		logic        fe;
		logic        oe;
		logic        rb;
	} uccore_state_t;

	uccore_state_t s_reg;
	uccore_state_t s_next;

	logic        rx;
	logic        cts_ok;
	logic        ext_rise;
	logic        ext_fall;
	logic        sync_m;
	logic        pre_tick;
	logic        os_int;
	logic        os_tick;
	logic        tx_tick;
	logic        rx_step;
	logic        rx_samp;
	logic        acc;
	logic        wr;
	logic        tx_go;
	logic        tx_rst;
	logic        rx_rst;
	logic [3:0]  nb;
	logic [15:0] div;
	logic [31:0] rd;

	function automatic logic uccore_par(input logic [7:0] d, input logic [3:0] n,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction : uccore_par

	always_comb begin
		s_next = s_reg;
		rx = s_reg.rx_s[1];
		cts_ok = ~s_reg.cts_s[1];
		ext_rise = s_reg.ext_s[1] & ~s_reg.ext_d;
		ext_fall = ~s_reg.ext_s[1] & s_reg.ext_d;
		sync_m = s_reg.csel[1];
		nb = uccore_pkg::BITS_MIN + {2'b00, s_reg.mode[1:0]};
		div = {s_reg.div_hi, s_reg.div_lo}; // RULE_23
		tx_rst = 1'b0;
		rx_rst = 1'b0;
		// synchronisers
		s_next.rx_s = {s_reg.rx_s[0], serial_rx_in};
		s_next.rx_d = rx;
		s_next.cts_s = {s_reg.cts_s[0], clear_to_send_in_n};
		s_next.ext_s = {s_reg.ext_s[0], timer_clock_pin};
		s_next.ext_d = s_reg.ext_s[1];
		// prescaler and divider; values below two are not guarded
		s_next.pre = s_reg.pre + 5'h01;
		pre_tick = s_reg.pre == uccore_pkg::PRE_LAST; // RULE_02
		os_int = pre_tick & ({1'b0, s_reg.divc} + 17'h00001 >= {1'b0, div}); // RULE_22
		if (pre_tick) begin
			s_next.divc = os_int ? 16'h0000 : s_reg.divc + 16'h0001;
		end
		// oversampling tick from the selected source
		os_tick = (s_reg.csel == uccore_pkg::CSEL_INT) ? os_int : ext_rise; // RULE_04 RULE_24 RULE_03
		s_next.cap_blk = s_reg.csel != uccore_pkg::CSEL_INT; // RULE_05
		// apb: request completes at the edge that sees pready
		acc = psel & penable & s_reg.pready;
		wr = acc & pwrite;
		s_next.pready = psel & penable & ~s_reg.pready;
		rd = 32'h00000000;
		s_next.pslverr = 1'b0;
		unique case (paddr)
			uccore_pkg::OFS_STATUS: begin
				rd = {24'h000000, s_reg.cts_s[1], s_reg.rb, s_reg.oe, s_reg.fe,
					s_reg.pe, s_reg.rx_ready, s_reg.tx_empty,
					s_reg.tx_en & ~s_reg.thr_full}; // RULE_06 RULE_19
			end
			uccore_pkg::OFS_DATA: rd = {24'h000000, s_reg.rhr};
			uccore_pkg::OFS_CLKSEL: rd = {30'h00000000, s_reg.csel};
			uccore_pkg::OFS_MODE: rd = {25'h0000000, s_reg.mode};
			uccore_pkg::OFS_CMD, uccore_pkg::OFS_DIVHI, uccore_pkg::OFS_DIVLO,
			uccore_pkg::OFS_RTS_SET, uccore_pkg::OFS_RTS_CLR: rd = 32'h00000000;
			default: s_next.pslverr = psel & penable & ~s_reg.pready;
		endcase
		if (psel & penable & ~s_reg.pready) begin
			s_next.prdata = pwrite ? 32'h00000000 : rd;
		end
		if (acc & ~pwrite & paddr == uccore_pkg::OFS_DATA) begin
			s_next.rx_ready = 1'b0;
		end
		if (wr) begin
			unique case (paddr)
				uccore_pkg::OFS_CLKSEL: s_next.csel = pwdata[1:0];
				uccore_pkg::OFS_DIVHI: s_next.div_hi = pwdata[7:0];
				uccore_pkg::OFS_DIVLO: s_next.div_lo = pwdata[7:0];
				uccore_pkg::OFS_MODE: s_next.mode = pwdata[6:0];
				uccore_pkg::OFS_DATA: begin
					if (~s_reg.thr_full) begin
						s_next.thr = pwdata[7:0];
						s_next.thr_full = 1'b1;
						s_next.tx_empty = 1'b0; // RULE_09
					end
				end
				uccore_pkg::OFS_CMD: begin
					if (pwdata[uccore_pkg::CMD_TX_EN]) s_next.tx_en = 1'b1;
					if (pwdata[uccore_pkg::CMD_TX_DIS]) s_next.tx_en = 1'b0; // RULE_10
					if (pwdata[uccore_pkg::CMD_RX_EN]) s_next.rx_en = 1'b1;
					if (pwdata[uccore_pkg::CMD_RX_DIS]) s_next.rx_en = 1'b0;
					if (pwdata[uccore_pkg::CMD_BRK_ON]) s_next.brk = 1'b1;
					if (pwdata[uccore_pkg::CMD_BRK_OFF]) s_next.brk = 1'b0;
					if (pwdata[uccore_pkg::CMD_ERR_RST]) begin
						s_next.pe = 1'b0;
						s_next.fe = 1'b0;
						s_next.oe = 1'b0;
						s_next.rb = 1'b0;
					end
					tx_rst = pwdata[uccore_pkg::CMD_TX_RST];
					rx_rst = pwdata[uccore_pkg::CMD_RX_RST];
				end
				default: ;
			endcase
		end
		// transmitter: shifts on the falling phase of the bit clock
		if (os_tick) begin
			s_next.tx_osc = s_reg.tx_osc + 4'h1;
		end
		tx_tick = sync_m ? ext_fall : (os_tick & s_reg.tx_osc == uccore_pkg::OS_LAST); // RULE_08
		tx_go = s_reg.thr_full & s_reg.tx_en & ~s_reg.brk &
			(~s_reg.mode[uccore_pkg::MODE_CTS_CHK] | cts_ok); // RULE_12 RULE_13
		if (tx_tick) begin
			unique case (s_reg.tx_st)
				uccore_pkg::TX_IDLE, uccore_pkg::TX_STOP: begin
					if (s_reg.tx_st == uccore_pkg::TX_STOP &
						s_reg.mode[uccore_pkg::MODE_STOP2] & s_reg.tx_bit == 4'h0) begin
						s_next.tx_bit = 4'h1;
					end else if (tx_go) begin
						s_next.tx_sh = s_reg.thr;
						s_next.tx_par = uccore_par(s_reg.thr, nb,
							s_reg.mode[uccore_pkg::MODE_PAR_ODD]);
						s_next.thr_full = 1'b0;
						s_next.tx_line = 1'b0; // RULE_07
						s_next.tx_st = uccore_pkg::TX_START;
					end else if (s_reg.tx_st == uccore_pkg::TX_STOP) begin
						s_next.tx_line = 1'b1; // RULE_09
						s_next.tx_empty = ~s_reg.thr_full;
						s_next.tx_st = (~s_reg.tx_en & s_reg.mode[uccore_pkg::MODE_AUTO_RTS])
							? uccore_pkg::TX_RTSW : uccore_pkg::TX_IDLE;
					end
				end
				uccore_pkg::TX_START, uccore_pkg::TX_DATA: begin
					if (s_reg.tx_st == uccore_pkg::TX_DATA & s_reg.tx_bit == nb) begin
						s_next.tx_bit = 4'h0;
						if (s_reg.mode[uccore_pkg::MODE_PAR_EN]) begin
							s_next.tx_line = s_reg.tx_par;
							s_next.tx_st = uccore_pkg::TX_PAR;
						end else begin
							s_next.tx_line = 1'b1;
							s_next.tx_st = uccore_pkg::TX_STOP;
						end
					end else begin
						s_next.tx_line = s_reg.tx_sh[0]; // RULE_07
						s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
						s_next.tx_bit = (s_reg.tx_st == uccore_pkg::TX_START) ? 4'h1
							: s_reg.tx_bit + 4'h1;
						s_next.tx_st = uccore_pkg::TX_DATA;
					end
				end
				uccore_pkg::TX_PAR: begin
					s_next.tx_line = 1'b1;
					s_next.tx_st = uccore_pkg::TX_STOP;
				end
				uccore_pkg::TX_RTSW: begin
					s_next.rts_n = 1'b1; // RULE_14
					s_next.tx_st = uccore_pkg::TX_IDLE;
				end
				default: s_next.tx_st = uccore_pkg::TX_IDLE;
			endcase
		end
		if (tx_rst) begin
			s_next.tx_st = uccore_pkg::TX_IDLE; // RULE_11
			s_next.tx_line = 1'b1;
			s_next.tx_en = 1'b0;
			s_next.thr_full = 1'b0;
			s_next.tx_empty = 1'b1;
			s_next.tx_bit = 4'h0;
		end
		// written after the engine so a software write wins the same edge
		if (wr & paddr == uccore_pkg::OFS_RTS_SET & pwdata[0]) s_next.rts_n = 1'b0; // RULE_01
		if (wr & paddr == uccore_pkg::OFS_RTS_CLR & pwdata[0]) s_next.rts_n = 1'b1; // RULE_01
		s_next.txo = s_next.tx_line & ~s_next.brk;
		// receiver: samples on the rising phase
		rx_step = sync_m ? ext_rise : os_tick;
		rx_samp = rx_step & (sync_m | s_reg.rx_osc == uccore_pkg::OS_LAST); // RULE_16
		if (rx_step) begin
			s_next.rx_osc = s_reg.rx_osc + 4'h1;
		end
		unique case (s_reg.rx_st)
			uccore_pkg::RX_IDLE: begin
				if (s_reg.rx_en & s_reg.rx_d & ~rx) begin
					s_next.rx_st = uccore_pkg::RX_START;
					s_next.rx_osc = 4'h0;
				end
			end
			uccore_pkg::RX_START: begin
				if (rx_step & rx) begin
					s_next.rx_st = uccore_pkg::RX_IDLE; // RULE_15
				end else if (rx_step & (sync_m | s_reg.rx_osc == uccore_pkg::HALF_LAST)) begin
					s_next.rx_st = uccore_pkg::RX_DATA; // RULE_15
					s_next.rx_osc = 4'h0;
					s_next.rx_bit = 4'h0;
					s_next.rx_sh = 8'h00;
				end
			end
			uccore_pkg::RX_DATA: begin
				if (rx_samp) begin
					s_next.rx_osc = 4'h0;
					s_next.rx_sh[s_reg.rx_bit[2:0]] = rx; // RULE_16
					s_next.rx_bit = s_reg.rx_bit + 4'h1;
					if (s_reg.rx_bit + 4'h1 == nb) begin
						s_next.rx_pbit = 1'b0;
						s_next.rx_st = s_reg.mode[uccore_pkg::MODE_PAR_EN]
							? uccore_pkg::RX_PAR : uccore_pkg::RX_STOP;
					end
				end
			end
			uccore_pkg::RX_PAR: begin
				if (rx_samp) begin
					s_next.rx_osc = 4'h0;
					s_next.rx_pbit = rx;
					s_next.rx_st = uccore_pkg::RX_STOP;
				end
			end
			uccore_pkg::RX_STOP: begin
				if (rx_samp) begin
					s_next.rx_osc = 4'h0;
					s_next.rhr = s_reg.rx_sh; // RULE_17
					s_next.rx_ready = 1'b1;
					s_next.oe = s_reg.rx_ready; // RULE_19
					s_next.pe = s_reg.mode[uccore_pkg::MODE_PAR_EN] &
						(s_reg.rx_pbit != uccore_par(s_reg.rx_sh, nb,
						s_reg.mode[uccore_pkg::MODE_PAR_ODD]));
					s_next.fe = ~rx;
					s_next.rb = ~rx & ~|s_reg.rx_sh & ~s_reg.rx_pbit; // RULE_20
					if (rx) begin
						s_next.rx_st = uccore_pkg::RX_IDLE; // RULE_18
					end else if (|s_reg.rx_sh) begin
						s_next.rx_st = uccore_pkg::RX_START; // RULE_18 RULE_21
					end else begin
						s_next.rx_st = uccore_pkg::RX_BRKW; // RULE_20
					end
				end
			end
			uccore_pkg::RX_BRKW: begin
				if (rx_step & ~rx) begin
					s_next.rx_osc = 4'h0;
				end else if (rx_step & (sync_m | s_reg.rx_osc == uccore_pkg::HALF_LAST)) begin
					s_next.rx_st = uccore_pkg::RX_IDLE; // RULE_20
				end
			end
			default: s_next.rx_st = uccore_pkg::RX_IDLE;
		endcase
		if (rx_rst) begin
			s_next.rx_st = uccore_pkg::RX_IDLE;
			s_next.rx_en = 1'b0;
			s_next.rx_ready = 1'b0;
			s_next.pe = 1'b0;
			s_next.fe = 1'b0;
			s_next.oe = 1'b0;
			s_next.rb = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.csel <= uccore_pkg::CSEL_RST;
			s_reg.div_hi <= uccore_pkg::DIV_RST;
			s_reg.div_lo <= uccore_pkg::DIV_RST;
			s_reg.mode <= uccore_pkg::MODE_RST;
			s_reg.rx_s <= 2'b11;
			s_reg.rx_d <= 1'b1;
			s_reg.cts_s <= 2'b11;
			s_reg.rts_n <= 1'b1;
			s_reg.txo <= 1'b1;
			s_reg.tx_line <= 1'b1;
			s_reg.tx_empty <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign serial_tx_out = s_reg.txo;
	assign request_to_send_out_n = s_reg.rts_n;
	assign timer_capture_blocked_out = s_reg.cap_blk;

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rts_assert: assert property (ce & wr & paddr == uccore_pkg::OFS_RTS_SET & pwdata[0] // RULE_01
		|=> !request_to_send_out_n) else $error("rts not asserted");
	a_rts_negate: assert property (ce & wr & paddr == uccore_pkg::OFS_RTS_CLR & pwdata[0] // RULE_01
		|=> request_to_send_out_n) else $error("rts not negated");
	a_int_prescale: assert property (s_reg.csel == uccore_pkg::CSEL_INT & os_tick // RULE_02
		|-> s_reg.pre == uccore_pkg::PRE_LAST) else $error("bit clock off prescale");
	a_ext_source: assert property (s_reg.csel != uccore_pkg::CSEL_INT & rx_step // RULE_03
		|-> ext_rise) else $error("external clock not used");
	a_capture_block: assert property (ce & s_reg.csel != uccore_pkg::CSEL_INT // RULE_05
		|=> timer_capture_blocked_out) else $error("capture not blocked");
	a_start_low: assert property (s_reg.tx_st == uccore_pkg::TX_START & ~s_reg.brk // RULE_07
		|-> !serial_tx_out) else $error("start bit not low");
	a_idle_mark: assert property ((s_reg.tx_st == uccore_pkg::TX_IDLE // RULE_09
		|| s_reg.tx_st == uccore_pkg::TX_STOP) & ~s_reg.brk |-> serial_tx_out)
		else $error("line not at mark");
	a_cts_hold: assert property (ce & s_reg.tx_st == uccore_pkg::TX_IDLE // RULE_12
		& s_reg.mode[uccore_pkg::MODE_CTS_CHK] & s_reg.cts_s[1]
		|=> s_reg.tx_st == uccore_pkg::TX_IDLE) else $error("started without cts");
	a_tx_reset: assert property (ce & tx_rst // RULE_11
		|=> s_reg.tx_st == uccore_pkg::TX_IDLE & !s_reg.tx_en) else $error("tx reset ignored");
	a_rx_store: assert property (ce & s_reg.rx_st == uccore_pkg::RX_STOP & rx_samp // RULE_17
		|=> s_reg.rx_ready & s_reg.rhr == $past(s_reg.rx_sh)) else $error("char not stored");

	c_tx_char: cover property (s_reg.tx_st == uccore_pkg::TX_STOP
		##1 s_reg.tx_st == uccore_pkg::TX_IDLE);
	c_rx_char: cover property (s_reg.rx_st == uccore_pkg::RX_STOP ##1 s_reg.rx_ready);
	c_rx_break: cover property (s_reg.rx_st == uccore_pkg::RX_BRKW);
	c_auto_rts: cover property (s_reg.tx_st == uccore_pkg::TX_RTSW);
endmodule : uccore_top
`default_nettype wire
